// ==== hdl/psq_pkg.sv ====
// package: widths, table layouts and reset values of the sequencer
package psq_pkg;

  // ==========================================================
  // sizes
  localparam int unsigned PSQ_IN_W       = 8;    // external inputs
  localparam int unsigned PSQ_OUT_W      = 16;   // output vector per state
  localparam int unsigned PSQ_STATE_W    = 8;    // state number width
  localparam int unsigned PSQ_STATES     = 256;  // state table entries
  localparam int unsigned PSQ_MAX_UNCOND = 192;  // unconditional transitions supported
  localparam int unsigned PSQ_BIDX_W     = 6;    // branch table index width
  localparam int unsigned PSQ_BRANCHES   = 64;   // multi-way branch expressions
  localparam int unsigned PSQ_CONDS      = 3;    // listed conditions per branch
  localparam int unsigned PSQ_TERMS      = 4;    // product terms per condition
  localparam int unsigned PSQ_SYNC_DEPTH = 2;    // flops on each input pin

  // ==========================================================
  // reset values
  localparam logic [7:0]  PSQ_INIT_STATE = 8'h00;   // first listed state
  localparam logic [15:0] PSQ_OUT_RST    = 16'h0000;
  localparam logic [7:0]  PSQ_IN_RST     = 8'h00;
  localparam logic [2:0]  PSQ_HIT_RST    = 3'h0;

  // ==========================================================
  // table layouts
  typedef struct packed {
    logic       en;    // term takes part in the sum
    logic [7:0] care;  // inputs that appear in the product
    logic [7:0] pol;   // 1: input true, 0: input inverted
  } psq_term_t;

  typedef struct packed {
    psq_term_t [PSQ_TERMS-1:0] term;
    logic [7:0]                next;       // successor state
    logic [5:0]                next_bidx;  // successor's own branch index
    logic [15:0]               next_out;   // successor's output vector
  } psq_cond_t;

  typedef struct packed {
    psq_cond_t [PSQ_CONDS-1:0] cond;  // cond[0] has highest priority
  } psq_branch_t;

  typedef struct packed {
    logic [15:0] out;        // this state's outputs
    logic        cond_en;    // 1: conditional branch, 0: unconditional
    logic [5:0]  bidx;       // this state's branch table entry
    logic [7:0]  dflt_next;  // default or unconditional successor
    logic [5:0]  dflt_bidx;  // default successor's branch index
    logic [15:0] dflt_out;   // default successor's outputs
  } psq_word_t;

  // ==========================================================
  // start-up and run phases, one-hot
  typedef enum logic [2:0] {
    PH_LOAD = 3'b001,  // reading initial state word
    PH_LINK = 3'b010,  // reading initial branch entry
    PH_RUN  = 3'b100   // one transition per clock
  } psq_phase_t;

  // all state of the sequencer core
  typedef struct packed {
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    psq_phase_t  phase;
    logic [7:0]  state;
    logic [15:0] outs;
    logic [2:0]  hit;
    logic        dflt;
    logic        running;
  } psq_core_t;

endpackage

// ==== hdl/psq_mem.sv ====
// memory: synchronous table with one write port and a registered read
`timescale 1ns/100ps
`default_nettype none

module psq_mem #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  input  wire logic             core_clk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ==========================================================
  // write and registered read; read returns old data on collision
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule
`default_nettype wire

// ==== hdl/psq_seq.sv ====
// sequencer: programmable priority-branch moore state machine
`timescale 1ns/100ps
`default_nettype none

module psq_seq
  import psq_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  input  wire logic                run_en,
  input  wire logic [PSQ_IN_W-1:0] seq_in,
  input  wire logic                cfg_state_we,
  input  wire logic                cfg_branch_we,
  input  wire logic [7:0]          cfg_addr,
  input  wire psq_word_t           cfg_state_data,
  input  wire psq_branch_t         cfg_branch_data,
  output logic [PSQ_OUT_W-1:0]     seq_out,
  output logic [PSQ_STATE_W-1:0]   seq_state,
  output logic                     seq_running,
  output logic [PSQ_CONDS-1:0]     seq_hit,
  output logic                     seq_dflt
);

  // ==========================================================
  // core register, its next value and the current table words
  psq_core_t    cur_ff;
  psq_core_t    nxt_cur;
  psq_word_t    sword;       // word of the current state
  psq_branch_t  bword;       // branch entry of the current state
  // table read addresses, steered by the phase
  logic [7:0]   st_rd_addr;
  logic [5:0]   br_rd_addr;
  // condition results and the successor they pick
  logic [2:0]   cond_true;
  logic [2:0]   cond_win;
  logic [7:0]   sel_next;
  logic [5:0]   sel_bidx;
  logic [15:0]  sel_out;
  logic [2:0]   sel_hit;
  logic         sel_dflt;

  // ==========================================================
  // tables
  // tables are not reset: load them while run_en is low
  // state table: one word per state, read at the successor
  psq_mem #(
    .WIDTH ($bits(psq_word_t)),
    .DEPTH (PSQ_STATES),
    .AW    (PSQ_STATE_W)
  ) u_state_tab (
    .core_clk (core_clk),
    .wr_en    (cfg_state_we),
    .wr_addr  (cfg_addr),
    .wr_data  (cfg_state_data),
    .rd_addr  (st_rd_addr),
    .rd_data  (sword)
  );

  // branch table: 64 entries, shared by all conditional states
  psq_mem #(
    .WIDTH ($bits(psq_branch_t)),
    .DEPTH (PSQ_BRANCHES),
    .AW    (PSQ_BIDX_W)
  ) u_branch_tab (
    .core_clk (core_clk),
    .wr_en    (cfg_branch_we),
    .wr_addr  (cfg_addr[5:0]),
    .wr_data  (cfg_branch_data),
    .rd_addr  (br_rd_addr),
    .rd_data  (bword)
  );

  // ==========================================================
  // condition evaluation
  // each condition is a sum of up to four products of synced inputs
  generate
    for (genvar c = 0; c < PSQ_CONDS; c++) begin : g_cond
      logic [PSQ_TERMS-1:0] term_true;
      for (genvar t = 0; t < PSQ_TERMS; t++) begin : g_term
        assign term_true[t] = bword.cond[c].term[t].en &
          (&(~bword.cond[c].term[t].care |
             ~(cur_ff.sync2 ^ bword.cond[c].term[t].pol)));
      end
      assign cond_true[c] = |term_true;
    end
  endgenerate

  // ==========================================================
  // priority mask
  // one-hot winner: a condition counts only if no earlier one is true
  generate
    for (genvar c = 0; c < PSQ_CONDS; c++) begin : g_prio
      if (c == 0) begin : g_first
        assign cond_win[c] = cond_true[c];
      end else begin : g_later
        assign cond_win[c] = cond_true[c] & ~(|cond_true[c-1:0]);
      end
    end
  endgenerate

  // ==========================================================
  // successor selection
  // priority encoder: lowest listed condition first, then default
  always_comb begin
    sel_next = sword.dflt_next;
    sel_bidx = sword.dflt_bidx;
    sel_out  = sword.dflt_out;
    sel_hit  = 3'h0;
    sel_dflt = 1'b1;
    if (sword.cond_en) begin
      if (cond_true[0]) begin
        sel_next = bword.cond[0].next;
        sel_bidx = bword.cond[0].next_bidx;
        sel_out  = bword.cond[0].next_out;
        sel_hit  = cond_win;
        sel_dflt = 1'b0;
      end else if (cond_true[1]) begin
        sel_next = bword.cond[1].next;
        sel_bidx = bword.cond[1].next_bidx;
        sel_out  = bword.cond[1].next_out;
        sel_hit  = cond_win;
        sel_dflt = 1'b0;
      end else if (cond_true[2]) begin
        sel_next = bword.cond[2].next;
        sel_bidx = bword.cond[2].next_bidx;
        sel_out  = bword.cond[2].next_out;
        sel_hit  = cond_win;
        sel_dflt = 1'b0;
      end
      // none true: default successor already selected
    end else begin
      sel_dflt = 1'b0;  // unconditional move, no default flag
    end
  end

  // ==========================================================
  // next core state and table read addresses
  always_comb begin
    nxt_cur       = cur_ff;
    // two-flop synchroniser; only sync2 feeds the conditions
    nxt_cur.sync1 = seq_in;
    nxt_cur.sync2 = cur_ff.sync1;
    st_rd_addr    = PSQ_INIT_STATE;
    br_rd_addr    = sword.bidx;
    case (cur_ff.phase)
      PH_LOAD: begin
        // initial state word arrives at the next edge
        nxt_cur.state   = PSQ_INIT_STATE;
        nxt_cur.outs    = PSQ_OUT_RST;
        nxt_cur.hit     = PSQ_HIT_RST;
        nxt_cur.dflt    = 1'b0;
        nxt_cur.running = 1'b0;
        if (run_en) begin
          nxt_cur.phase = PH_LINK;
        end
      end
      PH_LINK: begin
        // initial outputs shown, its branch entry fetched
        nxt_cur.outs    = sword.out;
        nxt_cur.running = run_en;
        nxt_cur.phase   = run_en ? PH_RUN : PH_LOAD;
      end
      PH_RUN: begin
        if (run_en) begin
          // one transition per edge, outputs move with the state
          st_rd_addr    = sel_next;
          br_rd_addr    = sel_bidx;
          nxt_cur.state = sel_next;
          nxt_cur.outs  = sel_out;
          nxt_cur.hit   = sel_hit;
          nxt_cur.dflt  = sel_dflt;
        end else begin
          nxt_cur.phase   = PH_LOAD;
          nxt_cur.running = 1'b0;
          nxt_cur.hit     = PSQ_HIT_RST;
          nxt_cur.dflt    = 1'b0;
        end
      end
      default: begin
        nxt_cur.phase   = PH_LOAD;
        nxt_cur.running = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // core register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff.sync1   <= PSQ_IN_RST;
      cur_ff.sync2   <= PSQ_IN_RST;
      cur_ff.phase   <= PH_LOAD;
      cur_ff.state   <= PSQ_INIT_STATE;
      cur_ff.outs    <= PSQ_OUT_RST;
      cur_ff.hit     <= PSQ_HIT_RST;
      cur_ff.dflt    <= 1'b0;
      cur_ff.running <= 1'b0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // outputs straight from the core register
  assign seq_out     = cur_ff.outs;
  assign seq_state   = cur_ff.state;
  assign seq_running = cur_ff.running;
  assign seq_hit     = cur_ff.hit;
  assign seq_dflt    = cur_ff.dflt;

endmodule
`default_nettype wire

// ==== tb/psq_seq_asserts.sv ====
// checker: port-level properties of the priority-branch sequencer
`timescale 1ns/100ps
`default_nettype none

module psq_seq_asserts
  import psq_pkg::*;
(
  input wire logic                   core_clk,
  input wire logic                   rst_b,
  input wire logic                   run_en,
  input wire logic [PSQ_OUT_W-1:0]   seq_out,
  input wire logic [PSQ_STATE_W-1:0] seq_state,
  input wire logic                   seq_running,
  input wire logic [PSQ_CONDS-1:0]   seq_hit,
  input wire logic                   seq_dflt
);
  // ==========================================================
  // properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  hit_onehot_a: assert property ($onehot0(seq_hit))
    else $error("several branch hits at once");
  dflt_excl_a: assert property (seq_dflt |-> seq_hit == 3'h0)
    else $error("default move with a hit");
  first_state_a: assert property ($rose(seq_running) |->
    seq_state == PSQ_INIT_STATE && seq_hit == 3'h0 && !seq_dflt)
    else $error("run did not start in initial state");
  start_delay_a: assert property ($rose(seq_running) |->
    $past(run_en) && $past(run_en, 2))
    else $error("run started too early");
  stop_run_a: assert property (!run_en [*4] |->
    !seq_running && seq_state == 8'h00)
    else $error("machine kept running without enable");
  run_hold_a: assert property (run_en && seq_running |=> seq_running)
    else $error("run phase dropped");
  state_move_a: assert property ($changed(seq_state) |->
    seq_running || seq_state == PSQ_INIT_STATE)
    else $error("state moved outside run phase");
  idle_out_a: assert property ($rose(seq_running) |-> $past(seq_out) == 16'h0000)
    else $error("outputs live before start");

  // main scenarios
  cov_dflt: cover property (seq_dflt);
  cov_first: cover property (seq_hit[0]);
  cov_last: cover property (seq_hit[2]);
endmodule

`default_nettype wire

// ==== tb/psq_env.sv ====
// partner: system logic that applies input vectors to the sequencer pins
`timescale 1ns/100ps
`default_nettype none

module psq_env (
  input  wire logic       core_clk,
  input  wire logic [7:0] vec,
  output logic      [7:0] seq_in
);
  // vector reaches the pins one edge after it is asked for
  always @(posedge core_clk) begin
    seq_in <= vec;
  end
endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
// testbench: loads a four-way branch program and checks one move out of state 0 per vector and every move out of states 1 to 3
`timescale 1ns/100ps
`default_nettype none

module testbench
  import psq_pkg::*;
();
  // ==========================================================
  // signals
  logic        core_clk = 1'b0, rst_b = 1'b0, run_en = 1'b0, prev_run = 1'b0;
  logic        cfg_state_we = 1'b0, cfg_branch_we = 1'b0, seq_running, seq_dflt;
  logic [7:0]  cfg_addr = 8'h00, vec = 8'h00, prev_state = 8'h00, seq_in, seq_state;
  logic [15:0] seq_out;
  logic [2:0]  seq_hit;
  logic [31:0] lfsr = 32'ha0a08442;
  logic [31:0] exp_q[$];
  psq_word_t   cfg_state_data = '0;
  psq_branch_t cfg_branch_data = '0;
  int          n_errors = 0, comparisons = 0;
  localparam logic [7:0] DIRS[5] = '{8'h03, 8'h01, 8'h00, 8'h84, 8'h04};

  always #5 core_clk = ~core_clk;

  psq_env psq_env_inst (.core_clk(core_clk), .vec(vec), .seq_in(seq_in));
  psq_seq psq_seq_inst (.core_clk(core_clk), .rst_b(rst_b), .run_en(run_en),
    .seq_in(seq_in), .cfg_state_we(cfg_state_we), .cfg_branch_we(cfg_branch_we),
    .cfg_addr(cfg_addr), .cfg_state_data(cfg_state_data),
    .cfg_branch_data(cfg_branch_data), .seq_out(seq_out), .seq_state(seq_state),
    .seq_running(seq_running), .seq_hit(seq_hit), .seq_dflt(seq_dflt));

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // expected {hit, dflt, out, state} after leaving state 0
  function automatic logic [31:0] expect_for(input logic [7:0] v);
    logic [3:0] f;
    logic [7:0] s;
    if (v[0] & v[1]) f = 4'b0001;
    else if (v[0]) f = 4'b0010;
    else if (!v[2] | v[7]) f = 4'b0100;
    else f = 4'b1000;
    s = f[0] ? 8'h01 : f[1] ? 8'h02 : f[2] ? 8'h03 : 8'h00;
    return {4'h0, f[2:0], f[3], 8'hc3, s, s};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("counts: %0d compares, %0d mismatches", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic put(input logic s_we, input logic [7:0] a, input psq_word_t w);
    @(posedge core_clk);
    cfg_state_we <= s_we;
    cfg_branch_we <= !s_we;
    cfg_addr <= a;
    cfg_state_data <= w;
    @(posedge core_clk);
    cfg_state_we <= 1'b0;
    cfg_branch_we <= 1'b0;
  endtask

  // apply a vector, note the expected move, wait for it to be seen
  task automatic drive(input logic [7:0] v);
    @(posedge core_clk);
    vec <= v;
    repeat (6) @(posedge core_clk);
    exp_q.push_back(expect_for(v));
    for (int k = 0; k < 10 && exp_q.size() > 0; k++) @(posedge core_clk);
    if (exp_q.size() > 0) begin
      n_errors++;
      finish_test();
    end
  endtask

  // monitor: a result is the move out of state 0
  always @(posedge core_clk) begin
    if (prev_run && seq_running && prev_state === 8'h00 && exp_q.size() > 0)
      check({4'h0, seq_hit, seq_dflt, seq_out, seq_state}, exp_q.pop_front());
    // unconditional states 1 to 3 always return to state 0, no hit, no default
    if (prev_run && seq_running && prev_state inside {8'h01, 8'h02, 8'h03})
      check({4'h0, seq_hit, seq_dflt, seq_out, seq_state}, 32'h00c30000);
    prev_state <= seq_state;
    prev_run <= seq_running;
  end

  // ==========================================================
  // main sequence
  initial begin
    psq_branch_t br;
    br = '0;
    br.cond[0].term[0] = '{1'b1, 8'h03, 8'h03};
    br.cond[1].term[0] = '{1'b1, 8'h01, 8'h01};
    br.cond[2].term[0] = '{1'b1, 8'h04, 8'h00};
    br.cond[2].term[3] = '{1'b1, 8'h80, 8'h80};
    for (int i = 0; i < 3; i++) begin
      br.cond[i].next = 8'(i + 1);
      br.cond[i].next_out = {8'hc3, 8'(i + 1)};
    end
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    cfg_branch_data <= br;
    put(1'b0, 8'h00, '0);
    for (int s = 0; s < 4; s++)
      put(1'b1, 8'(s), '{{8'hc3, 8'(s)}, s == 0, 6'h00, 8'h00, 6'h00, 16'hc300});
    run_en <= 1'b1;
    foreach (DIRS[i]) drive(DIRS[i]);
    $display("test branch priority done");
    for (int k = 0; k < 24; k++) begin
      lfsr = lfsr_next(lfsr);
      drive(lfsr[7:0]);
    end
    $display("test random inputs done");
    run_en <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1 check({23'h0, seq_running, seq_state}, 32'h0);
    @(posedge core_clk);
    run_en <= 1'b1;
    drive(8'h03);
    $display("test restart done");
    rst_b <= 1'b0;
    #1 check({3'h0, seq_hit, seq_dflt, seq_running, seq_out, seq_state}, 32'h0);
    $display("test reset done");
    finish_test();
  end
endmodule

bind psq_seq psq_seq_asserts psq_seq_asserts_inst (.core_clk(core_clk), .rst_b(rst_b),
  .run_en(run_en), .seq_out(seq_out), .seq_state(seq_state),
  .seq_running(seq_running), .seq_hit(seq_hit), .seq_dflt(seq_dflt));

`default_nettype wire
